/* File: shared/dbu_pkg.sv */
// Operation
// - full transmit word is 9 bits; top bit sent as ninth bit in extended mode
// - short transmit word holds 8 bits, never supplies a ninth bit
// - any write to either transmit word sets tx_in_progress (bit 7); code skips a write whose s_axi_wstrb[1:0] are both zero
// - frame end sets tx_done_irq and clears tx_in_progress together
// - parity mismatch on a received character sets parity_err_flag (bit 2)
// - missing stop bit sets framing_err_flag (bit 1)
// - reception done with buffer unread sets overrun_err_flag, buffer overwritten
// - with reception enabled, any error flag set raises rx_error_irq
// - with reception enabled, each buffer load raises rx_done_irq
// - each whole transmitted frame raises tx_done_irq
// - any change of the clear-to-send input raises cts_change_irq (bit 3)
// - interrupt flags clear only by writing one; zero leaves them
// - baud_count_enable (bit 7) runs or stops the baud generator
// - baud_code selects 1200 to 115200 bps; 4800 taken as code 010
// - reserved bits read as zero; software writes zero
// - frame sent lsb first after start bit; start, parity, stop added
// - error flags clear on buffer read or on next received character
// - dropping rx_enable mid-frame stops reception, no flags or interrupts
// - ninth bit applies only when parity_select is 00
package dbu_pkg;
  // register indices; byte address is four times the index
  localparam logic [31:0] IDX_TX_WIDE = 32'h0B0001AC;
  localparam logic [31:0] IDX_TX_BYTE = 32'h0B0001AE;
  localparam logic [31:0] IDX_LINE_STATUS = 32'h0B0001B0;
  localparam logic [31:0] IDX_IRQ_FLAGS = 32'h0B0001B2;
  localparam logic [31:0] IDX_BAUD = 32'h0B0001B6;
  localparam logic [31:0] IDX_MODE = 32'h0B0001C0;
  localparam logic [31:0] IDX_RX_BUF = 32'h0B0001C2;
  localparam logic [31:0] ADDR_TX_WIDE = IDX_TX_WIDE << 2;
  localparam logic [31:0] ADDR_TX_BYTE = IDX_TX_BYTE << 2;
  localparam logic [31:0] ADDR_LINE_STATUS = IDX_LINE_STATUS << 2;
  localparam logic [31:0] ADDR_IRQ_FLAGS = IDX_IRQ_FLAGS << 2;
  localparam logic [31:0] ADDR_BAUD = IDX_BAUD << 2;
  localparam logic [31:0] ADDR_MODE = IDX_MODE << 2;
  localparam logic [31:0] ADDR_RX_BUF = IDX_RX_BUF << 2;
  // reset values
  localparam logic [8:0] TX_WIDE_RST = 9'h1FF;
  localparam logic [7:0] TX_BYTE_RST = 8'hFF;
  // field positions
  localparam int LS_SOT = 7;
  localparam int IRQ_CTS = 3;
  localparam int IRQ_RXERR = 2;
  localparam int IRQ_RXDONE = 1;
  localparam int IRQ_TXDONE = 0;
  localparam int BAUD_EN = 7;
  localparam int MODE_RXE = 6;
  localparam int MODE_PS = 4;
  localparam int MODE_EBS = 0;
  // parity select codes
  localparam logic [1:0] PS_NONE = 2'h0;
  localparam logic [1:0] PS_ZERO = 2'h1;
  localparam logic [1:0] PS_ODD = 2'h2;
  localparam logic [1:0] PS_EVEN = 2'h3;
  // timing
  localparam int CLK_HZ = 200_000_000;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] SUB_HALF = 4'h7;
  localparam int unsigned BAUD_BPS [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/dbu_top.sv */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
module dbu_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic serial_tx_pin,
  input wire logic serial_rx_pin,
  input wire logic cts_n,
  output logic rts_n
);
  import dbu_pkg::*;

  typedef enum logic [4:0] {
    T_IDLE = 5'h01,
    T_START = 5'h02,
    T_DATA = 5'h04,
    T_PAR = 5'h08,
    T_STOP = 5'h10
  } dbu_tx_e;

  typedef enum logic [4:0] {
    R_IDLE = 5'h01,
    R_START = 5'h02,
    R_DATA = 5'h04,
    R_PAR = 5'h08,
    R_STOP = 5'h10
  } dbu_rx_e;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [15:0] rdata;
    logic [31:0] awa;
    logic [15:0] wd;
    logic [15:0] wm;
    logic [8:0] txw;
    logic [7:0] txb;
    logic sot;
    logic pe;
    logic fe;
    logic ove;
    logic [3:0] irq;
    logic brce;
    logic [2:0] bcode;
    logic rxe;
    logic [1:0] ps;
    logic ebs;
    logic [8:0] rxbuf;
    logic rxfull;
    logic [15:0] bcnt;
    logic tick;
    dbu_tx_e tst;
    logic [3:0] tsub;
    logic [3:0] tbit;
    logic [8:0] tsh;
    logic tpar;
    logic txd;
    dbu_rx_e rst;
    logic [3:0] rsub;
    logic [3:0] rbit;
    logic [8:0] rsh;
    logic rpar;
    logic cts_q;
    logic rtsn;
  } dbu_state_s;

  dbu_state_s s;
  dbu_state_s next_s;

  // outputs straight from the state register
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = {16'h0000, s.rdata};
  assign serial_tx_pin = s.txd;
  assign rts_n = s.rtsn;

  // next state of the whole block
  always_comb begin
    logic wr_go;
    logic wr_tx;
    logic wr_wide;
    logic ninth;
    logic [3:0] nb;
    logic [15:0] div;
    logic [15:0] wv;
    logic [8:0] rdat;
    logic perr;
    wr_go = 1'h0;
    wr_tx = 1'h0;
    wr_wide = 1'h0;
    rdat = 9'h000;
    perr = 1'h0;
    next_s = s;
    ninth = s.ebs && (s.ps == PS_NONE);
    nb = ninth ? 4'h9 : 4'h8;
    div = 16'(CLK_HZ / (OVERSAMPLE * BAUD_BPS[s.bcode]) - 1);
    wv = s.wd & s.wm;

    // baud tick at sixteen times the bit rate
    if (!s.brce) begin
      next_s.bcnt = 16'h0000;
      next_s.tick = 1'h0;
    end else if (s.bcnt >= div) begin
      next_s.bcnt = 16'h0000;
      next_s.tick = 1'h1;
    end else begin
      next_s.bcnt = s.bcnt + 16'h0001;
      next_s.tick = 1'h0;
    end

    // write channel: address and data taken in either order
    if (s.awready && s_axi_awvalid) begin
      next_s.awready = 1'h0;
      next_s.awa = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.wready = 1'h0;
      next_s.wd = s_axi_wdata[15:0];
      next_s.wm = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'h0;
      next_s.awready = 1'h1;
      next_s.wready = 1'h1;
    end
    wr_go = !s.awready && !s.wready && !s.bvalid;

    // register writes; reserved and read-only bits are dropped
    if (wr_go) begin
      next_s.bvalid = 1'h1;
      next_s.bresp = RESP_OKAY;
      case (s.awa)
        ADDR_TX_WIDE: begin
          next_s.txw = (s.txw & ~s.wm[8:0]) | wv[8:0];
          wr_tx = |s.wm;
          wr_wide = 1'h1;
        end
        ADDR_TX_BYTE: begin
          next_s.txb = (s.txb & ~s.wm[7:0]) | wv[7:0];
          wr_tx = |s.wm;
        end
        ADDR_IRQ_FLAGS: next_s.irq = s.irq & ~wv[3:0];
        ADDR_BAUD: begin
          if (s.wm[0]) begin
            next_s.brce = s.wd[BAUD_EN];
            next_s.bcode = s.wd[2:0];
          end
        end
        ADDR_MODE: begin
          if (s.wm[0]) begin
            next_s.rxe = s.wd[MODE_RXE];
            next_s.ps = s.wd[MODE_PS+:2];
            next_s.ebs = s.wd[MODE_EBS];
          end
        end
        ADDR_LINE_STATUS, ADDR_RX_BUF: ;
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end

    // read channel; reserved bits read as zero
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'h0;
      next_s.arready = 1'h1;
    end
    if (s.arready && s_axi_arvalid) begin
      next_s.arready = 1'h0;
      next_s.rvalid = 1'h1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 16'h0000;
      case (s_axi_araddr)
        ADDR_TX_WIDE: next_s.rdata[8:0] = s.txw;
        ADDR_TX_BYTE: next_s.rdata[7:0] = s.txb;
        ADDR_LINE_STATUS: next_s.rdata[7:0] = {s.sot, 4'h0, s.pe, s.fe, s.ove};
        ADDR_IRQ_FLAGS: next_s.rdata[3:0] = s.irq;
        ADDR_BAUD: next_s.rdata[7:0] = {s.brce, 4'h0, s.bcode};
        ADDR_MODE: next_s.rdata[7:0] = {1'h0, s.rxe, s.ps, 3'h0, s.ebs};
        ADDR_RX_BUF: begin
          next_s.rdata[8:0] = s.rxbuf;
          next_s.rxfull = 1'h0;
          next_s.pe = 1'h0;
          next_s.fe = 1'h0;
          next_s.ove = 1'h0;
        end
        default: next_s.rresp = RESP_SLVERR;
      endcase
    end

    // transmitter, one bit per sixteen ticks, lsb first
    if (s.tick) begin
      next_s.tsub = s.tsub + 4'h1;
    end
    case (s.tst)
      T_IDLE: next_s.tsub = 4'h0;
      T_START: begin
        if (s.tick && s.tsub == SUB_LAST) begin
          next_s.tst = T_DATA;
        end
      end
      T_DATA: begin
        if (s.tick && s.tsub == SUB_LAST) begin
          next_s.tsh = s.tsh >> 1;
          next_s.tbit = s.tbit + 4'h1;
          if (s.tbit == nb - 4'h1) begin
            next_s.tst = (s.ps == PS_NONE) ? T_STOP : T_PAR;
          end
        end
      end
      T_PAR: begin
        if (s.tick && s.tsub == SUB_LAST) begin
          next_s.tst = T_STOP;
        end
      end
      T_STOP: begin
        if (s.tick && s.tsub == SUB_LAST) begin
          next_s.tst = T_IDLE;
          next_s.sot = 1'h0;
          next_s.irq[IRQ_TXDONE] = 1'h1;
        end
      end
      default: next_s.tst = T_IDLE;
    endcase

    // receiver, sampling mid-bit from the sixteen-tick counter
    if (s.tick) begin
      next_s.rsub = s.rsub + 4'h1;
    end
    rdat = ninth ? s.rsh : {1'h0, s.rsh[8:1]};
    case (s.ps)
      PS_ODD: perr = (^rdat[7:0]) == s.rpar;
      PS_EVEN: perr = (^rdat[7:0]) != s.rpar;
      default: perr = 1'h0;
    endcase
    case (s.rst)
      R_IDLE: begin
        next_s.rsub = 4'h0;
        next_s.rbit = 4'h0;
        if (!serial_rx_pin) begin
          next_s.rst = R_START;
        end
      end
      R_START: begin
        if (s.tick && s.rsub == SUB_HALF) begin
          next_s.rsub = 4'h0;
          next_s.rst = serial_rx_pin ? R_IDLE : R_DATA;
        end
      end
      R_DATA: begin
        if (s.tick && s.rsub == SUB_LAST) begin
          next_s.rsh = {serial_rx_pin, s.rsh[8:1]};
          next_s.rbit = s.rbit + 4'h1;
          if (s.rbit == nb - 4'h1) begin
            next_s.rst = s.ps[1] ? R_PAR : R_STOP;
          end
        end
      end
      R_PAR: begin
        if (s.tick && s.rsub == SUB_LAST) begin
          next_s.rpar = serial_rx_pin;
          next_s.rst = R_STOP;
        end
      end
      R_STOP: begin
        if (s.tick && s.rsub == SUB_LAST && s.rxe) begin
          next_s.rst = R_IDLE;
          next_s.rxbuf = rdat;
          next_s.rxfull = 1'h1;
          next_s.pe = perr;
          next_s.fe = !serial_rx_pin;
          next_s.ove = s.rxfull;
          next_s.irq[IRQ_RXDONE] = 1'h1;
          if (perr || !serial_rx_pin || s.rxfull) begin
            next_s.irq[IRQ_RXERR] = 1'h1;
          end
        end
      end
      default: next_s.rst = R_IDLE;
    endcase
    if (!s.rxe) begin
      next_s.rst = R_IDLE;
    end
    next_s.rtsn = !next_s.rxe;

    // flow-control input change
    next_s.cts_q = cts_n;
    if (cts_n != s.cts_q) begin
      next_s.irq[IRQ_CTS] = 1'h1;
    end

    // transmit start wins over a same-cycle frame end
    if (wr_tx) begin
      next_s.sot = 1'h1;
      if (next_s.tst == T_IDLE) begin
        next_s.tst = T_START;
        next_s.tsub = 4'h0;
        next_s.tbit = 4'h0;
        if (wr_wide) begin
          next_s.tsh = ninth ? next_s.txw : {1'h0, next_s.txw[7:0]};
        end else begin
          next_s.tsh = {1'h0, next_s.txb};
        end
        case (s.ps)
          PS_ODD: next_s.tpar = ~^next_s.tsh[7:0];
          PS_EVEN: next_s.tpar = ^next_s.tsh[7:0];
          default: next_s.tpar = 1'h0;
        endcase
      end
    end

    // serial line level from the next transmit state
    case (next_s.tst)
      T_START: next_s.txd = 1'h0;
      T_DATA: next_s.txd = next_s.tsh[0];
      T_PAR: next_s.txd = next_s.tpar;
      default: next_s.txd = 1'h1;
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.awready <= 1'h1;
      s.wready <= 1'h1;
      s.arready <= 1'h1;
      s.txw <= TX_WIDE_RST;
      s.txb <= TX_BYTE_RST;
      s.tst <= T_IDLE;
      s.rst <= R_IDLE;
      s.txd <= 1'h1;
      s.cts_q <= 1'h1;
      s.rtsn <= 1'h1;
    end else begin
      s <= next_s;
    end
  end
endmodule

/* File: sim/dbu_chk_assertions.sv */
`timescale 1ns/10ps
module dbu_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic serial_tx_pin
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus answers stand until taken, then fall
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##[0:1] s_axi_awready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write slot not freed");
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##[0:1] s_axi_arready;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read slot not freed");
  // fixed answer latencies: one cycle for reads, two cycles for writes
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_aw_wait; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_wait: assert property (p_aw_wait) else $error("new write taken too early");
  property p_r_top; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_r_top: assert property (p_r_top) else $error("upper read bits set");
  property p_bit_len; $changed(serial_tx_pin) |=> $stable(serial_tx_pin) [*8]; endproperty
  a_bit_len: assert property (p_bit_len) else $error("serial bit too short");
endmodule

bind dbu_top dbu_chk i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .serial_tx_pin(serial_tx_pin));

/* File: sim/dbu_term.sv */
`timescale 1ns/10ps
module dbu_term #(parameter int BIT = 1728) (
  input wire logic clk,
  input wire logic rxd,
  output logic txd
);
  logic [8:0] got;
  int n_got = 0;
  int n_bits = 8;
  initial txd = 1'b1;
  // decode frames from the block at mid-bit; n_bits counts data and parity bits
  always begin
    @(negedge rxd);
    repeat (BIT / 2) @(posedge clk);
    got = '0;
    for (int i = 0; i < n_bits; i++) begin
      repeat (BIT) @(posedge clk);
      got[i] = rxd;
    end
    repeat (BIT) @(posedge clk);
    if (rxd) n_got++;
  end
  // send n bits lsb first after the start bit; a low stop breaks framing
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    txd <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      txd <= d[i];
      repeat (BIT) @(posedge clk);
    end
    txd <= stop;
    repeat (BIT) @(posedge clk);
    txd <= 1'b1;
  endtask
endmodule

/* File: sim/debug_uart_tx_status_baud_tb.sv */
`timescale 1ns/10ps
module debug_uart_tx_status_baud_tb;
  import dbu_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, serial_tx_pin, serial_rx_pin, rts_n;
  logic cts_n = 1;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [7:0] d0, d1, d2, d3, d4;
  int err_count = 0;
  int n_checks = 0;
  int seed = 66924;
  always #2.5 aclk = ~aclk;
  dbu_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .serial_tx_pin(serial_tx_pin), .serial_rx_pin(serial_rx_pin), .cts_n(cts_n),
    .rts_n(rts_n));
  dbu_term #(.BIT(16 * (CLK_HZ / (OVERSAMPLE * BAUD_BPS[7])))) i_term (.clk(aclk),
    .rxd(serial_tx_pin), .txd(serial_rx_pin));
  // expected line status word from its four flags
  function automatic logic [15:0] lsr(input logic [3:0] f);
    return {8'h00, f[3], 4'h0, f[2:0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [15:0] e);
    rdr(a);
    chk(rd, {16'h0000, e});
  endtask
  task automatic wrap_up;
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog against a hung handshake or frame
  initial begin
    repeat (98000) @(posedge aclk);
    err_count++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(ADDR_TX_WIDE, {7'h00, TX_WIDE_RST});
    rchk(ADDR_TX_BYTE, {8'h00, TX_BYTE_RST});
    rchk(ADDR_LINE_STATUS, lsr(4'h0));
    rchk(ADDR_IRQ_FLAGS, 16'h0000);
    rdr(ADDR_TX_WIDE + 32'h4);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(ADDR_TX_WIDE + 32'h4, 16'h0000);
    chk({30'h0, br}, {30'h0, RESP_SLVERR});
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_BAUD, 16'hFF78 | 16'(c));
      rchk(ADDR_BAUD, 16'(c));
    end
    wr(ADDR_BAUD, 16'h0087);
    chk({30'h0, br}, {30'h0, RESP_OKAY});
    d0 = 8'($random(seed));
    wr(ADDR_TX_BYTE, {8'h00, d0});
    rchk(ADDR_LINE_STATUS, lsr(4'h8));
    rchk(ADDR_TX_BYTE, {8'h00, d0});
    rd = 32'h80;
    while (rd[LS_SOT]) rdr(ADDR_LINE_STATUS);
    chk(i_term.got, d0);
    chk(i_term.n_got, 1);
    rchk(ADDR_IRQ_FLAGS, 16'h0001);
    wr(ADDR_IRQ_FLAGS, 16'h0000);
    rchk(ADDR_IRQ_FLAGS, 16'h0001);
    wr(ADDR_IRQ_FLAGS, 16'h0001);
    rchk(ADDR_IRQ_FLAGS, 16'h0000);
    @(posedge aclk);
    cts_n <= 1'b0;
    rchk(ADDR_IRQ_FLAGS, 16'h0008);
    wr(ADDR_IRQ_FLAGS, 16'h0008);
    wr(ADDR_MODE, 16'h0040);
    chk({31'h0, rts_n}, 32'h0);
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    i_term.send({1'b0, d1}, 8, 1'b1);
    rchk(ADDR_IRQ_FLAGS, 16'h0002);
    rchk(ADDR_LINE_STATUS, lsr(4'h0));
    i_term.send({1'b0, d2}, 8, 1'b0);
    rchk(ADDR_LINE_STATUS, lsr(4'h3));
    rchk(ADDR_IRQ_FLAGS, 16'h0006);
    rchk(ADDR_RX_BUF, {8'h00, d2});
    rchk(ADDR_LINE_STATUS, lsr(4'h0));
    // the low stop bit looks like a new start; dropping reception kills that frame
    wr(ADDR_MODE, 16'h0000);
    chk({31'h0, rts_n}, 32'h1);
    // even parity with the ninth bit asked for: parity wins, both ways at once
    wr(ADDR_IRQ_FLAGS, 16'h000F);
    wr(ADDR_MODE, 16'h0071);
    d3 = 8'($random(seed));
    i_term.n_bits = 9;
    wr(ADDR_TX_WIDE, {7'h00, 1'b1, d3});
    i_term.send({~^d3, d3}, 9, 1'b1);
    rd = 32'h80;
    while (rd[LS_SOT]) rdr(ADDR_LINE_STATUS);
    chk(i_term.got, {^d3, d3});
    chk(i_term.n_got, 2);
    rchk(ADDR_LINE_STATUS, lsr(4'h4));
    rchk(ADDR_IRQ_FLAGS, 16'h0007);
    rchk(ADDR_RX_BUF, {8'h00, d3});
    // ninth bit both ways
    wr(ADDR_IRQ_FLAGS, 16'h000F);
    wr(ADDR_MODE, 16'h0041);
    d4 = 8'($random(seed));
    wr(ADDR_TX_WIDE, {7'h00, 1'b1, d4});
    i_term.send({1'b1, d4}, 9, 1'b1);
    rd = 32'h80;
    while (rd[LS_SOT]) rdr(ADDR_LINE_STATUS);
    chk(i_term.got, {1'b1, d4});
    chk(i_term.n_got, 3);
    rchk(ADDR_RX_BUF, {7'h00, 1'b1, d4});
    rchk(ADDR_IRQ_FLAGS, 16'h0003);
    wrap_up();
  end
endmodule
